/* File: pkg/pcg_consts.svh */
// Offsets, field positions and reset values of the PCI cycle generator.
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH

// Configuration register offsets in PCI I/O space.
`define PCG_CFG_ADDR_OFF 32'h0000_0cf8
`define PCG_CFG_DATA_OFF 32'h0000_0cfc

// Configuration address register fields.
`define PCG_CFG_EN_BIT 31
`define PCG_CFG_BUS_HI 23
`define PCG_CFG_BUS_LO 16
`define PCG_CFG_DEV_HI 15
`define PCG_CFG_DEV_LO 11
`define PCG_CFG_FUNC_HI 10
`define PCG_CFG_FUNC_LO 8
`define PCG_CFG_REG_HI 7
`define PCG_CFG_REG_LO 2
`define PCG_CFG_ADDR_WMASK 32'h80ff_fffc
`define PCG_CFG_ADDR_RESET 32'h0000_0000

// Device numbers with special select decoding.
`define PCG_DEV_TOP_LINE 5'h00
`define PCG_DEV_FIRST_IDSEL 5'h0b
`define PCG_DEV_LAST_IDSEL 5'h1e
`define PCG_SPECIAL_DEV 5'h1f
`define PCG_SPECIAL_FUNC 3'h7
`define PCG_SPECIAL_REG 6'h00
`define PCG_TYPE1_LOW 2'h1

// Window three reset: processor 0x8000_0000 onward maps to PCI I/O 0.
`define PCG_WIN3_BASE_RESET 32'h8000_0000
`define PCG_WIN3_MASK_RESET 32'hff80_0000
`define PCG_WIN3_OFFSET_RESET 32'h8000_0000
`define PCG_WIN3_SPREAD_RESET 32'h8000_0000
`define PCG_CFG_WINDOW 3

// Processor address of the interrupt acknowledge port.
`define PCG_IACK_ADDR 32'hfeff_0030

`endif

/* File: pkg/pcg_pkg.sv */
// Types shared by the PCI cycle generator modules.
package pcg_pkg;

	typedef enum logic [3:0] {
		CMD_IACK = 4'h0,
		CMD_SPECIAL = 4'h1,
		CMD_IO_RD = 4'h2,
		CMD_IO_WR = 4'h3,
		CMD_MEM_RD = 4'h6,
		CMD_MEM_WR = 4'h7,
		CMD_CFG_RD = 4'ha,
		CMD_CFG_WR = 4'hb
	} pcg_cmd_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_PCI = 2'h1,
		ST_ACK = 2'h2
	} pcg_state_enum_type;

	typedef struct packed {
		logic enable;
		logic mem;
		logic io_mode_select;
		logic [31:0] base;
		logic [31:0] mask;
		logic [31:0] offset;
		logic [31:0] spread_offset;
	} pcg_window_type;

	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} pcg_cpu_req_type;

	typedef struct packed {
		logic valid;
		pcg_cmd_type cmd;
		logic [31:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} pcg_pci_req_type;

	typedef struct packed {
		logic valid;
		logic special;
		logic type1;
		logic [31:0] addr;
	} pcg_cfg_decode_type;

	typedef struct packed {
		pcg_state_enum_type state;
		logic [31:0] cfg_addr;
		pcg_window_type win3;
		pcg_pci_req_type pci;
		logic ack;
		logic miss;
		logic [31:0] rdata;
	} pcg_state_type;

endpackage

/* File: verilog/pcg_win_xlate.sv */
// Window hit test and processor to PCI address translation.
`timescale 1ns/1ps
module pcg_win_xlate
	import pcg_pkg::*;
(
	// Window setting and processor address
	input wire pcg_window_type i_win,
	input wire logic [31:0] i_addr,
	// Translation result
	output logic o_hit,
	output logic o_mem,
	output logic [31:0] o_pci_addr
);

	logic [31:0] flat_addr;
	logic [31:0] spread_addr;

	always_comb begin
		o_hit = i_win.enable && ((i_addr & i_win.mask) == i_win.base);
		o_mem = i_win.mem;
		flat_addr = i_addr + i_win.offset;
		spread_addr = i_addr + i_win.spread_offset;
		if (i_win.mem) begin
			o_pci_addr = flat_addr;
		end else if (!i_win.io_mode_select) begin
			o_pci_addr = flat_addr;
		end else begin
			// Each 4 KB processor page carries 32 bytes of PCI I/O space.
			o_pci_addr = {11'h000, spread_addr[27:12], spread_addr[4:0]};
		end
	end

endmodule

/* File: verilog/pcg_cfg_decode.sv */
// Turns the configuration address register into a PCI address phase.
`timescale 1ns/1ps
`include "pcg_consts.svh"
module pcg_cfg_decode
	import pcg_pkg::*;
(
	// Stored configuration address
	input wire logic [31:0] i_cfg_addr,
	// Decoded cycle
	output pcg_cfg_decode_type o_dec
);

	logic [7:0] bus_num;
	logic [4:0] dev_num;
	logic [2:0] func_num;
	logic [5:0] reg_num;
	logic [31:0] idsel;

	always_comb begin
		bus_num = i_cfg_addr[`PCG_CFG_BUS_HI:`PCG_CFG_BUS_LO];
		dev_num = i_cfg_addr[`PCG_CFG_DEV_HI:`PCG_CFG_DEV_LO];
		func_num = i_cfg_addr[`PCG_CFG_FUNC_HI:`PCG_CFG_FUNC_LO];
		reg_num = i_cfg_addr[`PCG_CFG_REG_HI:`PCG_CFG_REG_LO];
		idsel = 32'h0000_0000;
		if (dev_num == `PCG_DEV_TOP_LINE) begin
			idsel[31] = 1'b1;
		end else if (dev_num >= `PCG_DEV_FIRST_IDSEL && dev_num <= `PCG_DEV_LAST_IDSEL) begin
			idsel[dev_num] = 1'b1;
		end
		o_dec.valid = i_cfg_addr[`PCG_CFG_EN_BIT];
		o_dec.type1 = (bus_num != 8'h00);
		o_dec.special = (bus_num == 8'h00) && (dev_num == `PCG_SPECIAL_DEV) &&
			(func_num == `PCG_SPECIAL_FUNC) && (reg_num == `PCG_SPECIAL_REG);
		if (o_dec.type1) begin
			o_dec.addr = {8'h00, i_cfg_addr[23:2], `PCG_TYPE1_LOW};
		end else begin
			o_dec.addr = idsel | {21'h000000, func_num, reg_num, 2'h0};
		end
	end

endmodule

/* File: verilog/pcg_cycle_gen.sv */
// PCI cycle generator: processor accesses in, PCI transaction requests out.
`timescale 1ns/1ps
`include "pcg_consts.svh"
module pcg_cycle_gen
	import pcg_pkg::*;
#(
	parameter int NUM_WIN = 4
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Processor bus slave
	input wire pcg_cpu_req_type i_cpu_req,
	output logic o_cpu_ack,
	output logic o_cpu_miss,
	output logic [31:0] o_cpu_rdata,
	// Slave window settings; entry three is replaced by the loadable window
	input wire pcg_window_type [NUM_WIN-1:0] i_win_cfg,
	input wire logic i_win3_load,
	input wire pcg_window_type i_win3_cfg,
	// PCI master engine
	output pcg_pci_req_type o_pci_req,
	input wire logic i_pci_done,
	input wire logic [31:0] i_pci_rdata,
	// Status
	output logic [31:0] o_cfg_addr,
	output logic o_busy
);

	////////////////////////////////////////////////////////////////////////////////

	if (NUM_WIN < 4) begin : g_bad_num_win
		$error("pcg_cycle_gen needs at least four slave windows");
	end

	pcg_state_type q;
	pcg_state_type d;
	logic [NUM_WIN-1:0] win_hit;
	logic [NUM_WIN-1:0] win_mem;
	logic [31:0] win_pci_addr [NUM_WIN];
	pcg_cfg_decode_type cfg_dec;

	////////////////////////////////////////////////////////////////////////////////
	// Per-window translation.

	for (genvar w = 0; w < NUM_WIN; w++) begin : g_win
		pcg_window_type win_sel;
		assign win_sel = (w == `PCG_CFG_WINDOW) ? q.win3 : i_win_cfg[w];
		pcg_win_xlate u_xlate (
			.i_win(win_sel),
			.i_addr(i_cpu_req.addr),
			.o_hit(win_hit[w]),
			.o_mem(win_mem[w]),
			.o_pci_addr(win_pci_addr[w])
		);
	end

	pcg_cfg_decode u_cfg_decode (
		.i_cfg_addr(q.cfg_addr),
		.o_dec(cfg_dec)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Access decode.

	// A configuration access must be one, two or four bytes on aligned lanes.
	function automatic logic be_width_ok(input logic [3:0] be);
		case (be)
			4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf: be_width_ok = 1'b1;
			default: be_width_ok = 1'b0;
		endcase
	endfunction

	logic any_hit;
	logic sel_mem;
	logic [31:0] sel_addr;
	logic sel_cfg_win;
	logic iack_hit;
	logic at_cfg_addr;
	logic at_cfg_data;
	logic width_ok;

	always_comb begin
		any_hit = 1'b0;
		sel_mem = 1'b0;
		sel_addr = 32'h0000_0000;
		sel_cfg_win = 1'b0;
		// Lowest numbered window wins when windows overlap.
		for (int w = NUM_WIN - 1; w >= 0; w--) begin
			if (win_hit[w]) begin
				any_hit = 1'b1;
				sel_mem = win_mem[w];
				sel_addr = win_pci_addr[w];
				sel_cfg_win = (w == `PCG_CFG_WINDOW);
			end
		end
		iack_hit = ({i_cpu_req.addr[31:2], 2'h0} == `PCG_IACK_ADDR);
		// Only window three in I/O mode reaches the configuration pair.
		at_cfg_addr = sel_cfg_win && !sel_mem && ({sel_addr[31:2], 2'h0} == `PCG_CFG_ADDR_OFF);
		at_cfg_data = sel_cfg_win && !sel_mem && ({sel_addr[31:2], 2'h0} == `PCG_CFG_DATA_OFF);
		width_ok = be_width_ok(i_cpu_req.be);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		d = q;
		d.ack = 1'b0;
		if (i_win3_load) begin
			d.win3 = i_win3_cfg;
		end
		case (q.state)
			ST_IDLE: begin
				if (i_cpu_req.valid) begin
					d.miss = 1'b0;
					d.pci.be = i_cpu_req.be;
					d.pci.wdata = i_cpu_req.wdata;
					if (iack_hit) begin
						if (!i_cpu_req.write) begin
							// One read, one acknowledge cycle, byte enables as given.
							d.pci.valid = 1'b1;
							d.pci.cmd = CMD_IACK;
							d.pci.addr = 32'h0000_0000;
							d.pci.be = i_cpu_req.be;
							d.state = ST_PCI;
						end else begin
							d.ack = 1'b1;
							d.state = ST_ACK;
						end
					end else if (!any_hit) begin
						d.miss = 1'b1;
						d.rdata = 32'h0000_0000;
						d.ack = 1'b1;
						d.state = ST_ACK;
					end else if (at_cfg_addr && width_ok) begin
						if (i_cpu_req.write) begin
							// Storing the address starts nothing on PCI.
							for (int b = 0; b < 4; b++) begin
								if (i_cpu_req.be[b]) begin
									d.cfg_addr[b*8 +: 8] = i_cpu_req.wdata[b*8 +: 8];
								end
							end
							d.cfg_addr = d.cfg_addr & `PCG_CFG_ADDR_WMASK;
						end else begin
							d.rdata = q.cfg_addr;
						end
						d.ack = 1'b1;
						d.state = ST_ACK;
					end else if (at_cfg_data && width_ok && cfg_dec.valid) begin
						d.pci.valid = 1'b1;
						d.pci.addr = cfg_dec.addr;
						if (i_cpu_req.write && cfg_dec.special) begin
							d.pci.cmd = CMD_SPECIAL;
							d.pci.wdata = i_cpu_req.wdata;
						end else if (i_cpu_req.write) begin
							d.pci.cmd = CMD_CFG_WR;
						end else begin
							d.pci.cmd = CMD_CFG_RD;
						end
						d.state = ST_PCI;
					end else begin
						// Bad setup or width on the pair falls through to plain I/O.
						d.pci.valid = 1'b1;
						d.pci.addr = sel_addr;
						if (sel_mem) begin
							d.pci.cmd = i_cpu_req.write ? CMD_MEM_WR : CMD_MEM_RD;
						end else begin
							d.pci.cmd = i_cpu_req.write ? CMD_IO_WR : CMD_IO_RD;
						end
						d.state = ST_PCI;
					end
				end
			end
			ST_PCI: begin
				if (i_pci_done) begin
					d.pci.valid = 1'b0;
					if (q.pci.cmd == CMD_IACK || q.pci.cmd == CMD_IO_RD ||
						q.pci.cmd == CMD_MEM_RD || q.pci.cmd == CMD_CFG_RD) begin
						d.rdata = i_pci_rdata;
					end
					d.ack = 1'b1;
					d.state = ST_ACK;
				end
			end
			ST_ACK: begin
				// The processor drops its request while the acknowledge stands.
				d.state = ST_IDLE;
			end
			default: begin
				d.state = ST_IDLE;
				d.pci.valid = 1'b0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			q.state <= ST_IDLE;
			q.cfg_addr <= `PCG_CFG_ADDR_RESET;
			q.win3.enable <= 1'b1;
			q.win3.mem <= 1'b0;
			q.win3.io_mode_select <= 1'b0;
			q.win3.base <= `PCG_WIN3_BASE_RESET;
			q.win3.mask <= `PCG_WIN3_MASK_RESET;
			q.win3.offset <= `PCG_WIN3_OFFSET_RESET;
			q.win3.spread_offset <= `PCG_WIN3_SPREAD_RESET;
			q.pci.valid <= 1'b0;
			q.pci.cmd <= CMD_IACK;
			q.pci.addr <= 32'h0000_0000;
			q.pci.be <= 4'h0;
			q.pci.wdata <= 32'h0000_0000;
			q.ack <= 1'b0;
			q.miss <= 1'b0;
			q.rdata <= 32'h0000_0000;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign o_cpu_ack = q.ack;
	assign o_cpu_miss = q.miss;
	assign o_cpu_rdata = q.rdata;
	assign o_pci_req = q.pci;
	assign o_cfg_addr = q.cfg_addr;
	assign o_busy = (q.state != ST_IDLE);

endmodule

/* File: test/pcg_pci_target_model.sv */
// Behavioural PCI master engine and target seen from the cycle generator.
`timescale 1ns/1ps
module pcg_pci_target_model
	import pcg_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Request in, completion out
	input wire pcg_pci_req_type i_req,
	output logic o_done,
	output logic [31:0] o_rdata
);
	logic [2:0] wait_q;
	logic slow_q;
	logic [31:0] noise_q = 32'h0000_0001;

	// Latency alternates between prompt and slow; data is noise outside the done cycle.
	always @(posedge i_clk) begin
		noise_q <= noise_q + 32'h9e37_79b9;
		o_done <= 1'b0;
		o_rdata <= noise_q;
		if (i_reset) begin
			wait_q <= 3'h0;
			slow_q <= 1'b0;
		end else if (i_req.valid && !o_done) begin
			if (wait_q == (slow_q ? 3'h3 : 3'h0)) begin
				o_done <= 1'b1;
				o_rdata <= ~i_req.addr ^ {i_req.be, 28'h0};
				wait_q <= 3'h0;
				slow_q <= !slow_q;
			end else begin
				wait_q <= wait_q + 3'h1;
			end
		end
	end
endmodule

/* File: test/pcg_cycle_gen_sva.sv */
// Port-level checks of the PCI cycle generator.
`timescale 1ns/1ps
module pcg_cycle_gen_sva
	import pcg_pkg::*;
#(
	parameter int NUM_WIN = 4
)
(
	// Watched ports
	input wire logic i_clk,
	input wire logic i_reset,
	input wire pcg_cpu_req_type i_cpu_req,
	input wire logic o_cpu_ack,
	input wire logic o_cpu_miss,
	input wire logic [31:0] o_cpu_rdata,
	input wire pcg_window_type [NUM_WIN-1:0] i_win_cfg,
	input wire logic i_win3_load,
	input wire pcg_window_type i_win3_cfg,
	input wire pcg_pci_req_type o_pci_req,
	input wire logic i_pci_done,
	input wire logic [31:0] i_pci_rdata,
	input wire logic [31:0] o_cfg_addr,
	input wire logic o_busy
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	wire logic taken = i_cpu_req.valid && !o_busy;
	wire logic is_cfg = o_pci_req.valid && (o_pci_req.cmd == CMD_CFG_RD || o_pci_req.cmd == CMD_CFG_WR);

	////////////////////////////////////////////////////////////////
	chk_read_vector: assert property (i_pci_done && o_pci_req.valid && !o_pci_req.cmd[0]
		|=> o_cpu_ack && !o_pci_req.valid && o_cpu_rdata == $past(i_pci_rdata)) else $error("read data not returned");
	chk_req_hold: assert property (o_pci_req.valid && !i_pci_done
		|=> o_pci_req.valid && $stable(o_pci_req)) else $error("pci request changed before done");
	chk_cfgaddr_store: assert property (taken && i_cpu_req.write && i_cpu_req.addr == 32'h8000_0cf8 && i_cpu_req.be == 4'hf
		|=> o_cpu_ack && !o_pci_req.valid && o_cfg_addr == ($past(i_cpu_req.wdata) & 32'h80ff_fffc)) else $error("address write");
	chk_iack_start: assert property (taken && !i_cpu_req.write && i_cpu_req.addr == 32'hfeff_0030
		|=> o_pci_req.valid && o_pci_req.cmd == CMD_IACK && o_pci_req.be == $past(i_cpu_req.be)) else $error("iack");
	chk_cmd_legal: assert property (o_pci_req.valid |-> o_pci_req.cmd inside {CMD_IACK, CMD_SPECIAL, CMD_IO_RD,
		CMD_IO_WR, CMD_MEM_RD, CMD_MEM_WR, CMD_CFG_RD, CMD_CFG_WR}) else $error("illegal command");
	chk_type1_addr: assert property (is_cfg && o_cfg_addr[23:16] != 8'h00
		|-> o_pci_req.addr == {8'h00, o_cfg_addr[23:2], 2'h1}) else $error("type 1 address wrong");
	chk_type0_low: assert property (is_cfg && o_cfg_addr[23:16] == 8'h00
		|-> o_pci_req.addr[10:0] == {o_cfg_addr[10:2], 2'h0}) else $error("type 0 low address wrong");
	chk_special_data: assert property (o_pci_req.valid && o_pci_req.cmd == CMD_SPECIAL
		|-> o_pci_req.wdata == i_cpu_req.wdata && o_cfg_addr == 32'h8000_ff00) else $error("special cycle wrong");
	chk_ack_single: assert property (o_cpu_ack |=> !o_cpu_ack && !o_busy) else $error("ack not single");
	cov_iack: cover property (o_pci_req.valid && o_pci_req.cmd == CMD_IACK && i_pci_done);
	cov_special: cover property (o_pci_req.valid && o_pci_req.cmd == CMD_SPECIAL && i_pci_done);
	cov_type1: cover property (is_cfg && o_pci_req.addr[1:0] == 2'h1);
endmodule

bind pcg_cycle_gen pcg_cycle_gen_sva #(.NUM_WIN(NUM_WIN)) pcg_cycle_gen_sva_inst (.i_clk, .i_reset, .i_cpu_req,
	.o_cpu_ack, .o_cpu_miss, .o_cpu_rdata, .i_win_cfg, .i_win3_load, .i_win3_cfg, .o_pci_req, .i_pci_done,
	.i_pci_rdata, .o_cfg_addr, .o_busy);

/* File: test/pcg_cycle_gen_tb.sv */
// Self-checking bench of the PCI cycle generator.
`timescale 1ns/1ps
module pcg_cycle_gen_tb
	import pcg_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	pcg_cpu_req_type cpu = '0;
	pcg_window_type [3:0] win;
	pcg_pci_req_type pci, seen;
	logic ack, miss, busy, done;
	logic [31:0] rdata, cfg, prd;
	int err_count = 0, checks = 0, nreq = 0, cyc = 0;
	logic w3_load = 1'b0;
	pcg_window_type w3_cfg = '0;

	assign win[0] = '{1'b1, 1'b1, 1'b0, 32'h4000_0000, 32'hff00_0000, 32'h1000_0000, 32'h0};
	assign win[1] = '{1'b1, 1'b0, 1'b0, 32'h5000_0000, 32'hff00_0000, 32'hb000_0000, 32'h0};
	assign win[2] = '{1'b1, 1'b0, 1'b1, 32'h6000_0000, 32'hff00_0000, 32'h0, 32'ha000_0000};
	assign win[3] = '0;
	always #25 i_clk = ~i_clk;

	pcg_cycle_gen #(.NUM_WIN(4)) pcg_cycle_gen_inst (.i_clk(i_clk), .i_reset(i_reset), .i_cpu_req(cpu),
		.o_cpu_ack(ack), .o_cpu_miss(miss), .o_cpu_rdata(rdata), .i_win_cfg(win), .i_win3_load(w3_load),
		.i_win3_cfg(w3_cfg), .o_pci_req(pci), .i_pci_done(done), .i_pci_rdata(prd), .o_cfg_addr(cfg),
		.o_busy(busy));
	pcg_pci_target_model pcg_pci_target_model_inst (.i_clk(i_clk), .i_reset(i_reset), .i_req(pci),
		.o_done(done), .o_rdata(prd));

	////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (pci.valid === 1'b1 && done === 1'b1) begin
			seen <= pci;
			nreq <= nreq + 1;
		end
		if (cyc == 3000) begin
			err_count = err_count + 1;
			stop_test();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic pc(input logic [3:0] c, input logic [31:0] a);
		chk("pci cmd", {28'h0, c}, {28'h0, seen.cmd});
		chk("pci addr", a, seen.addr);
	endtask

	// Holds the request until ack is sampled high, then releases it.
	task automatic acc(input logic w, input logic [31:0] a, input logic [3:0] be, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_clk);
		cpu <= '{1'b1, w, a, be, d};
		do begin
			@(posedge i_clk);
			n++;
		end while (ack !== 1'b1 && n < 40);
		cpu.valid <= 1'b0;
		if (n >= 40) chk("ack", 32'h1, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_windows();
		acc(1'b1, 32'h4000_0124, 4'hf, 32'h1234_5678);
		pc(CMD_MEM_WR, 32'h5000_0124);
		acc(1'b0, 32'h5000_0010, 4'hf, 32'h0);
		pc(CMD_IO_RD, 32'h0000_0010);
		chk("io data", 32'h0fff_ffef, rdata);
		acc(1'b0, 32'h4000_0200, 4'hf, 32'h0);
		pc(CMD_MEM_RD, 32'h5000_0200);
		chk("mem data", 32'h5fff_fdff, rdata);
		acc(1'b1, 32'h6000_3008, 4'hf, 32'h0);
		pc(CMD_IO_WR, 32'h0000_0068);
		acc(1'b0, 32'h1000_0000, 4'hf, 32'h0);
		chk("miss", 32'h1, {31'h0, miss});
		chk("miss data", 32'h0, rdata);
		$display("test windows done");
	endtask

	task automatic t_config();
		logic [31:0] cv[7] = '{32'hff00_5a13, 32'h8000_0210, 32'h8000_f010, 32'h8000_f810, 32'h8003_5a10,
			32'h0000_5a10, 32'h8000_5a10};
		logic [3:0] bv[7] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'h5};
		logic [31:0] ev[7] = '{32'h0000_0a10, 32'h8000_0210, 32'h4000_0010, 32'h0000_0010, 32'h0003_5a11,
			32'h0000_0cfc, 32'h0000_0cfc};
		logic [3:0] cm[7] = '{4'hb, 4'hb, 4'hb, 4'hb, 4'hb, 4'h3, 4'h3};
		int n;
		for (int i = 0; i < 7; i++) begin
			n = nreq;
			acc(1'b1, 32'h8000_0cf8, 4'hf, cv[i]);
			chk("no cycle", n, nreq);
			acc(1'b0, 32'h8000_0cf8, 4'hf, 32'h0);
			chk("cfg read", cv[i] & 32'h80ff_fffc, rdata);
			acc(1'b1, 32'h8000_0cfc, bv[i], 32'h0000_0001);
			pc(cm[i], ev[i]);
		end
		acc(1'b0, 32'h8000_0cfc, 4'hf, 32'h0);
		pc(CMD_CFG_RD, 32'h0000_0a10);
		chk("cfg data", 32'h0fff_f5ef, rdata);
		chk("no miss", 32'h0, {31'h0, miss});
		$display("test config done");
	endtask

	task automatic t_special();
		acc(1'b1, 32'h8000_0cf8, 4'hf, 32'h8000_ff00);
		acc(1'b1, 32'h8000_0cfc, 4'hf, 32'hcafe_0123);
		pc(CMD_SPECIAL, 32'h0000_0700);
		chk("special data", 32'hcafe_0123, seen.wdata);
		acc(1'b0, 32'h8000_0cfc, 4'hf, 32'h0);
		pc(CMD_CFG_RD, 32'h0000_0700);
		chk("special read", 32'h0fff_f8ff, rdata);
		$display("test special done");
	endtask

	task automatic t_iack();
		int n;
		n = nreq;
		acc(1'b0, 32'hfeff_0030, 4'h6, 32'h0);
		pc(CMD_IACK, 32'h0);
		chk("iack be", 32'h6, {28'h0, seen.be});
		chk("iack vector", 32'h9fff_ffff, rdata);
		acc(1'b1, 32'hfeff_0030, 4'hf, 32'h0);
		chk("iack count", n + 1, nreq);
		$display("test iack done");
	endtask

	// Moves window three away, merges one address byte, and checks the old place misses.
	task automatic t_win3();
		int n;
		n = nreq;
		@(posedge i_clk);
		w3_cfg <= '{1'b1, 1'b0, 1'b0, 32'h9000_0000, 32'hff80_0000, 32'h7000_0000, 32'h0};
		w3_load <= 1'b1;
		@(posedge i_clk);
		w3_load <= 1'b0;
		acc(1'b1, 32'h9000_0cf8, 4'h2, 32'h0000_ab00);
		acc(1'b0, 32'h9000_0cf8, 4'hf, 32'h0);
		chk("merged cfg", 32'h8000_ab00, rdata);
		chk("no cycle", n, nreq);
		acc(1'b0, 32'h8000_0cf8, 4'hf, 32'h0);
		chk("old window", 32'h1, {31'h0, miss});
		$display("test window three done");
	endtask

	initial begin
		repeat (12) @(posedge i_clk);
		i_reset <= 1'b0;
		t_windows();
		t_config();
		t_special();
		t_iack();
		t_win3();
		stop_test();
	end
endmodule
